// *** misc_cfg.svh ***
`ifndef MISC_CFG_SVH
`define MISC_CFG_SVH

// primary opcodes, instruction bits 15:8
`define OPC_CCR_AND     8'h83
`define OPC_CCR_OR      8'h93
`define OPC_ILM_SET     8'h87
`define OPC_SP_ADD      8'hA3
`define OPC_EXT_GROUP   8'h97
`define OPC_LOAD_LOW    8'h8C
`define OPC_LOAD_HIGH   8'h8D
`define OPC_STORE_LOW   8'h8E
`define OPC_STORE_HIGH  8'h8F
`define OPC_FRAME_ENTER 8'h0F
`define OPC_E_GROUP     8'h9F
`define OPC_BYTE_XCHG   8'h8A

// secondary opcodes, instruction bits 7:4
`define SUB_EXT_SB      4'h8
`define SUB_EXT_UB      4'h9
`define SUB_EXT_SH      4'hA
`define SUB_EXT_UH      4'hB
`define SUB_FRAME_EXIT  4'h9
`define SUB_NOP         4'hA

// fixed register numbers
`define REG_STACK_PTR   4'hF
`define REG_FRAME_PTR   4'hE

// word step on the stack, and shift of scaled immediates
`define WORD_BYTES      32'h0000_0004
`define IMM_SCALE_SHIFT 2

// reset values
`define CCR_RESET       8'h00
`define ILM_RESET       8'h00

// default cycle parameters (a, b, c of the core timing)
`define CYC_A_DEFAULT   2
`define CYC_B_DEFAULT   2
`define CYC_C_DEFAULT   1

`endif

// *** misc_pkg.sv ***
package misc_pkg;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_NOP,
    OP_CCR_AND,
    OP_CCR_OR,
    OP_ILM,
    OP_SP_ADD,
    OP_EXT,
    OP_LDM,
    OP_STM,
    OP_ENTER,
    OP_LEAVE,
    OP_BYTE_EXCHANGE
  } op_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACC,
    ST_WAIT
  } state_e;

endpackage

// *** reglist_scan.sv ***
`timescale 1ns/10ps
// picks one register out of an 8-bit list: lowest set bit, or highest when high_first
module reglist_scan (
  // list in
  input  wire logic [7:0] list,
  input  wire logic       high_first,
  // pick out
  output logic      [2:0] idx,
  output logic            any,
  output logic            more
);

  logic [7:0] rest;

  always_comb begin
    idx = 3'h0;
    any = |list;
    if (high_first) begin
      for (int i = 0; i < 8; i++) begin
        if (list[i]) begin
          idx = 3'(i);
        end
      end
    end else begin
      for (int i = 7; i >= 0; i--) begin
        if (list[i]) begin
          idx = 3'(i);
        end
      end
    end
    rest = list & ~(8'h01 << idx);
    more = |rest;
  end

endmodule

// *** ext_unit.sv ***
`timescale 1ns/10ps
// byte and halfword extension to 32 bits; mode 0 sb, 1 ub, 2 sh, 3 uh
module ext_unit (
  // operand
  input  wire logic [31:0] val,
  input  wire logic [1:0]  mode,
  // result
  output logic      [31:0] res
);

  always_comb begin
    case (mode)
      2'h0:    res = {{24{val[7]}}, val[7:0]};
      2'h1:    res = {24'h00_0000, val[7:0]};
      2'h2:    res = {{16{val[15]}}, val[15:0]};
      default: res = {16'h0000, val[15:0]};
    endcase
  end

endmodule

// *** misc_instruction_execute.sv ***
`timescale 1ns/10ps
`include "misc_cfg.svh"
// What this block does
// - the and-mask opcode ANDs its immediate into the condition codes, the or-mask opcode ORs it.
// - the mask-set opcode loads its immediate into the interrupt level mask in one cycle.
// - the stack add opcode adds the sign-extended field times four to the stack pointer in one cycle.
// - the byte extension opcodes sign- or zero-extend the low byte of a register in place in one cycle.
// - the half extension opcodes sign- or zero-extend the low halfword in place in one cycle.
// - the multi-load opcodes fill listed low or high registers from the stack, stepping the pointer per word.
// - a multi-load of n registers takes a*(n-1)+b+1 cycles.
// - the multi-store opcodes push listed low or high registers, decrementing the pointer before each word.
// - a multi-store of n registers takes a*n+1 cycles.
// - frame entry saves the frame pointer below the stack pointer, moves both, and takes 1+a cycles.
// - the frame size field is the size divided by four, so it is scaled by four.
// - frame exit sets the stack pointer to frame pointer plus four, reloads the frame pointer, in b cycles.
// - the byte exchange swaps a byte between Ri and memory at Rj through a temporary in 2a cycles.
module misc_instruction_execute #(
  parameter int CYC_A = `CYC_A_DEFAULT,
  parameter int CYC_B = `CYC_B_DEFAULT,
  parameter int CYC_C = `CYC_C_DEFAULT
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // instruction in
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr,
  output logic             instr_ready,
  output logic             op_unknown,
  // register file read ports
  output logic      [3:0]  rf_rd_a_addr,
  input  wire logic [31:0] rf_rd_a_data,
  output logic      [3:0]  rf_rd_b_addr,
  input  wire logic [31:0] rf_rd_b_data,
  // register file write ports
  output logic             rf_wa_en,
  output logic      [3:0]  rf_wa_addr,
  output logic      [31:0] rf_wa_data,
  output logic             rf_wb_en,
  output logic      [3:0]  rf_wb_addr,
  output logic      [31:0] rf_wb_data,
  // data memory port
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_byte,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic [31:0] mem_rdata,
  // status
  output logic      [7:0]  condition_code_reg,
  output logic      [7:0]  irq_level_mask
);

  if (CYC_A < 2 || CYC_A > 255 || CYC_B < 2 || CYC_B > 255 || CYC_C < 1 || CYC_C > 255) begin : g_chk
    $error("cycle parameters out of range");
  end

  localparam logic [7:0] A_M1 = 8'(CYC_A - 1);
  localparam logic [7:0] A_M2 = 8'(CYC_A - 2);
  localparam logic [7:0] B_M1 = 8'(CYC_B - 1);
  localparam logic [7:0] B_M2 = 8'(CYC_B - 2);
  localparam logic [7:0] C_M2 = 8'(CYC_C - 2);

  function automatic misc_pkg::op_e decode(input logic [15:0] ins);
    misc_pkg::op_e o;
    o = misc_pkg::OP_NONE;
    case (ins[15:8])
      `OPC_CCR_AND:     o = misc_pkg::OP_CCR_AND;
      `OPC_CCR_OR:      o = misc_pkg::OP_CCR_OR;
      `OPC_ILM_SET:     o = misc_pkg::OP_ILM;
      `OPC_SP_ADD:      o = misc_pkg::OP_SP_ADD;
      `OPC_LOAD_LOW,
      `OPC_LOAD_HIGH:   o = misc_pkg::OP_LDM;
      `OPC_STORE_LOW,
      `OPC_STORE_HIGH:  o = misc_pkg::OP_STM;
      `OPC_FRAME_ENTER: o = misc_pkg::OP_ENTER;
      `OPC_BYTE_XCHG:   o = misc_pkg::OP_BYTE_EXCHANGE;
      `OPC_EXT_GROUP: begin
        if (ins[7:4] >= `SUB_EXT_SB && ins[7:4] <= `SUB_EXT_UH) begin
          o = misc_pkg::OP_EXT;
        end
      end
      `OPC_E_GROUP: begin
        if (ins[7:4] == `SUB_FRAME_EXIT) begin
          o = misc_pkg::OP_LEAVE;
        end else if (ins[7:4] == `SUB_NOP) begin
          o = misc_pkg::OP_NOP;
        end
      end
      default: o = misc_pkg::OP_NONE;
    endcase
    return o;
  endfunction

  // scaled 8-bit field: size or offset divided by four, times four again
  function automatic logic [31:0] scale4(input logic [7:0] f, input logic sgn);
    return {{22{sgn & f[7]}}, f, 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  misc_pkg::state_e state_r;
  misc_pkg::op_e    op_r;
  misc_pkg::op_e    op;
  logic [7:0]       cnt_r;
  logic [7:0]       list_r;
  logic [2:0]       cur_r;
  logic             base_r;
  logic             phase_r;
  logic [3:0]       ri_r;
  logic [7:0]       imm_r;
  logic [31:0]      sp_r;
  logic [31:0]      temp_r;
  logic [31:0]      addr_r;
  logic [31:0]      wdata_r;
  logic             we_r;
  logic             byte_r;
  logic             accept;
  logic             last;
  logic [2:0]       first_idx;
  logic             first_any;
  logic             first_more;
  logic [7:0]       list_nxt;
  logic [2:0]       next_idx;
  logic             next_any;
  logic             next_more;
  logic [31:0]      ext_res;

  assign op          = decode(instr);
  assign instr_ready = (state_r == misc_pkg::ST_IDLE);
  assign accept      = instr_valid && instr_ready;
  assign op_unknown  = accept && (op == misc_pkg::OP_NONE);
  assign last        = (state_r == misc_pkg::ST_ACC) && (cnt_r == 8'h00);
  assign list_nxt    = list_r & ~(8'h01 << cur_r);
  assign mem_req     = (state_r == misc_pkg::ST_ACC);
  assign mem_we      = we_r;
  assign mem_byte    = byte_r;
  assign mem_addr    = addr_r;
  assign mem_wdata   = wdata_r;

  // stores walk the list from the top so a later load walks it from the bottom
  reglist_scan u_first (
    .list       (instr[7:0]),
    .high_first (op == misc_pkg::OP_STM),
    .idx        (first_idx),
    .any        (first_any),
    .more       (first_more)
  );

  reglist_scan u_next (
    .list       (list_nxt),
    .high_first (op_r == misc_pkg::OP_STM),
    .idx        (next_idx),
    .any        (next_any),
    .more       (next_more)
  );

  ext_unit u_ext (
    .val  (rf_rd_a_data),
    .mode (instr[5:4]),
    .res  (ext_res)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // read port steering
  always_comb begin
    rf_rd_a_addr = instr[3:0];
    rf_rd_b_addr = `REG_STACK_PTR;
    if (state_r != misc_pkg::ST_IDLE) begin
      rf_rd_a_addr = {base_r, next_idx};
    end else if (op == misc_pkg::OP_STM) begin
      rf_rd_a_addr = {instr[8], first_idx};
    end else if (op == misc_pkg::OP_ENTER) begin
      rf_rd_a_addr = `REG_FRAME_PTR;
    end else if (op == misc_pkg::OP_BYTE_EXCHANGE) begin
      rf_rd_b_addr = instr[7:4];
    end else if (op == misc_pkg::OP_LEAVE) begin
      rf_rd_b_addr = `REG_FRAME_PTR;
    end
  end

  // register writes are combinational so the next instruction sees them at once
  always_comb begin
    rf_wa_en   = 1'b0;
    rf_wa_addr = 4'h0;
    rf_wa_data = 32'h0000_0000;
    rf_wb_en   = 1'b0;
    rf_wb_addr = `REG_STACK_PTR;
    rf_wb_data = 32'h0000_0000;
    if (accept) begin
      case (op)
        misc_pkg::OP_SP_ADD: begin
          rf_wb_en   = 1'b1;
          rf_wb_data = rf_rd_b_data + scale4(instr[7:0], 1'b1);
        end
        misc_pkg::OP_EXT: begin
          rf_wa_en   = 1'b1;
          rf_wa_addr = instr[3:0];
          rf_wa_data = ext_res;
        end
        default: rf_wa_en = 1'b0;
      endcase
    end else if (last) begin
      case (op_r)
        // loaded word and stepped pointer; a loaded stack pointer wins
        misc_pkg::OP_LDM: begin
          rf_wa_en   = 1'b1;
          rf_wa_addr = {base_r, cur_r};
          rf_wa_data = mem_rdata;
          rf_wb_en   = ({base_r, cur_r} != `REG_STACK_PTR);
          rf_wb_data = addr_r + `WORD_BYTES;
        end
        // pointer already decremented for this word
        misc_pkg::OP_STM: begin
          rf_wb_en   = 1'b1;
          rf_wb_data = addr_r;
        end
        // new frame and scaled frame size
        misc_pkg::OP_ENTER: begin
          rf_wa_en   = 1'b1;
          rf_wa_addr = `REG_FRAME_PTR;
          rf_wa_data = addr_r;
          rf_wb_en   = 1'b1;
          rf_wb_data = sp_r - scale4(imm_r, 1'b0);
        end
        misc_pkg::OP_LEAVE: begin
          rf_wa_en   = 1'b1;
          rf_wa_addr = `REG_FRAME_PTR;
          rf_wa_data = mem_rdata;
          rf_wb_en   = 1'b1;
          rf_wb_data = addr_r + `WORD_BYTES;
        end
        misc_pkg::OP_BYTE_EXCHANGE: begin
          rf_wa_en   = !phase_r;
          rf_wa_addr = ri_r;
          rf_wa_data = {24'h00_0000, mem_rdata[7:0]};
        end
        default: rf_wa_en = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // condition codes and level mask
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      condition_code_reg <= `CCR_RESET;
      irq_level_mask     <= `ILM_RESET;
    end else if (accept) begin
      if (op == misc_pkg::OP_CCR_AND) begin
        condition_code_reg <= condition_code_reg & instr[7:0];
      end else if (op == misc_pkg::OP_CCR_OR) begin
        condition_code_reg <= condition_code_reg | instr[7:0];
      end
      if (op == misc_pkg::OP_ILM) begin
        irq_level_mask <= instr[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer; every access window is cnt+1 cycles and the op ends on its last one
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= misc_pkg::ST_IDLE;
      op_r    <= misc_pkg::OP_NONE;
      cnt_r   <= 8'h00;
      list_r  <= 8'h00;
      cur_r   <= 3'h0;
      base_r  <= 1'b0;
      phase_r <= 1'b0;
      ri_r    <= 4'h0;
      imm_r   <= 8'h00;
      sp_r    <= 32'h0000_0000;
      temp_r  <= 32'h0000_0000;
      addr_r  <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      we_r    <= 1'b0;
      byte_r  <= 1'b0;
    end else begin
      case (state_r)
        misc_pkg::ST_IDLE: begin
          if (accept) begin
            op_r    <= op;
            list_r  <= instr[7:0];
            cur_r   <= first_idx;
            base_r  <= instr[8];
            imm_r   <= instr[7:0];
            ri_r    <= instr[3:0];
            phase_r <= 1'b0;
            byte_r  <= 1'b0;
            case (op)
              misc_pkg::OP_CCR_AND,
              misc_pkg::OP_CCR_OR: begin
                if (CYC_C > 1) begin
                  state_r <= misc_pkg::ST_WAIT;
                  cnt_r   <= C_M2;
                end
              end
              // one setup cycle, then a per word and b for the final word
              misc_pkg::OP_LDM: begin
                if (first_any) begin
                  state_r <= misc_pkg::ST_ACC;
                  cnt_r   <= first_more ? A_M1 : B_M1;
                  addr_r  <= rf_rd_b_data;
                  we_r    <= 1'b0;
                end
              end
              // one setup cycle, then a per word
              misc_pkg::OP_STM: begin
                if (first_any) begin
                  state_r <= misc_pkg::ST_ACC;
                  cnt_r   <= A_M1;
                  addr_r  <= rf_rd_b_data - `WORD_BYTES;
                  wdata_r <= rf_rd_a_data;
                  we_r    <= 1'b1;
                end
              end
              // frame pointer save window of a cycles
              misc_pkg::OP_ENTER: begin
                state_r <= misc_pkg::ST_ACC;
                cnt_r   <= A_M1;
                sp_r    <= rf_rd_b_data;
                addr_r  <= rf_rd_b_data - `WORD_BYTES;
                wdata_r <= rf_rd_a_data;
                we_r    <= 1'b1;
              end
              // old frame word sits at the frame pointer itself
              misc_pkg::OP_LEAVE: begin
                state_r <= misc_pkg::ST_ACC;
                cnt_r   <= B_M2;
                addr_r  <= rf_rd_b_data;
                we_r    <= 1'b0;
              end
              // Ri into the temporary, then read window of a-1 cycles
              misc_pkg::OP_BYTE_EXCHANGE: begin
                state_r <= misc_pkg::ST_ACC;
                cnt_r   <= A_M2;
                addr_r  <= rf_rd_b_data;
                temp_r  <= rf_rd_a_data;
                we_r    <= 1'b0;
                byte_r  <= 1'b1;
              end
              // nothing to do beyond the accept cycle
              default: state_r <= misc_pkg::ST_IDLE;
            endcase
          end
        end
        misc_pkg::ST_ACC: begin
          if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            state_r <= misc_pkg::ST_IDLE;
            case (op_r)
              misc_pkg::OP_LDM: begin
                if (next_any) begin
                  state_r <= misc_pkg::ST_ACC;
                  cnt_r   <= next_more ? A_M1 : B_M1;
                  addr_r  <= addr_r + `WORD_BYTES;
                  list_r  <= list_nxt;
                  cur_r   <= next_idx;
                end
              end
              misc_pkg::OP_STM: begin
                if (next_any) begin
                  state_r <= misc_pkg::ST_ACC;
                  cnt_r   <= A_M1;
                  addr_r  <= addr_r - `WORD_BYTES;
                  wdata_r <= rf_rd_a_data;
                  list_r  <= list_nxt;
                  cur_r   <= next_idx;
                end
              end
              // temporary back to memory at Rj in a cycles
              misc_pkg::OP_BYTE_EXCHANGE: begin
                if (!phase_r) begin
                  state_r <= misc_pkg::ST_ACC;
                  phase_r <= 1'b1;
                  cnt_r   <= A_M1;
                  wdata_r <= {24'h00_0000, temp_r[7:0]};
                  we_r    <= 1'b1;
                end
              end
              default: state_r <= misc_pkg::ST_IDLE;
            endcase
          end
        end
        misc_pkg::ST_WAIT: begin
          if (cnt_r == 8'h00) begin
            state_r <= misc_pkg::ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: state_r <= misc_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // cycle accounting watched by the checks below
  function automatic logic [15:0] expect_cycles(input misc_pkg::op_e o, input logic [7:0] l);
    int n;
    int e;
    n = $countones(l);
    e = 1;
    case (o)
      misc_pkg::OP_LDM:   e = (n == 0) ? 1 : CYC_A * (n - 1) + CYC_B + 1;
      misc_pkg::OP_STM:   e = (n == 0) ? 1 : CYC_A * n + 1;
      misc_pkg::OP_ENTER: e = 1 + CYC_A;
      misc_pkg::OP_LEAVE: e = CYC_B;
      misc_pkg::OP_BYTE_EXCHANGE:  e = 2 * CYC_A;
      default:            e = CYC_C;
    endcase
    return 16'(e);
  endfunction

  logic [15:0]   cyc_r;
  logic [15:0]   exp_r;
  misc_pkg::op_e kind_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cyc_r  <= 16'h0000;
      exp_r  <= 16'h0000;
      kind_r <= misc_pkg::OP_NONE;
    end else if (accept) begin
      cyc_r  <= 16'h0001;
      exp_r  <= expect_cycles(op, instr[7:0]);
      kind_r <= op;
    end else if (!instr_ready) begin
      cyc_r <= cyc_r + 16'h0001;
    end
  end

  ccr_and_update_a: assert property (@(posedge clk_sys) disable iff (rst)
    accept && op == misc_pkg::OP_CCR_AND |=>
      condition_code_reg == ($past(condition_code_reg) & $past(instr[7:0])))
    else $error("and-mask result wrong");

  ccr_or_update_a: assert property (@(posedge clk_sys) disable iff (rst)
    accept && op == misc_pkg::OP_CCR_OR |=>
      condition_code_reg == ($past(condition_code_reg) | $past(instr[7:0])))
    else $error("or-mask result wrong");

  ilm_load_a: assert property (@(posedge clk_sys) disable iff (rst)
    accept && op == misc_pkg::OP_ILM |=> irq_level_mask == $past(instr[7:0]) && instr_ready)
    else $error("level mask not loaded in one cycle");

  sp_add_a: assert property (@(posedge clk_sys) disable iff (rst)
    accept && op == misc_pkg::OP_SP_ADD |-> rf_wb_en && rf_wb_addr == `REG_STACK_PTR &&
      rf_wb_data - rf_rd_b_data == {{22{instr[7]}}, instr[7:0], 2'b00} ##1 instr_ready)
    else $error("stack add wrong");

  ext_single_a: assert property (@(posedge clk_sys) disable iff (rst)
    accept && op == misc_pkg::OP_EXT |-> rf_wa_en && rf_wa_addr == instr[3:0] &&
      rf_wa_data[7:0] == rf_rd_a_data[7:0] ##1 instr_ready)
    else $error("extension wrong");

  ldm_cycles_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(instr_ready) && kind_r == misc_pkg::OP_LDM |-> cyc_r == exp_r)
    else $error("multi-load cycle count wrong");

  stm_cycles_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(instr_ready) && kind_r == misc_pkg::OP_STM |-> cyc_r == exp_r)
    else $error("multi-store cycle count wrong");

  stm_predec_a: assert property (@(posedge clk_sys) disable iff (rst)
    accept && op == misc_pkg::OP_STM && first_any |=>
      mem_req && mem_we && mem_addr == $past(rf_rd_b_data) - `WORD_BYTES)
    else $error("store not predecremented");

  enter_frame_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(instr_ready) && kind_r == misc_pkg::OP_ENTER |-> cyc_r == exp_r &&
      $past(rf_wa_data) == $past(sp_r) - `WORD_BYTES)
    else $error("frame entry wrong");

  leave_cycles_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(instr_ready) && kind_r == misc_pkg::OP_LEAVE |-> cyc_r == exp_r)
    else $error("frame exit cycle count wrong");

  byte_exchange_cycles_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(instr_ready) && kind_r == misc_pkg::OP_BYTE_EXCHANGE |-> cyc_r == exp_r)
    else $error("byte exchange cycle count wrong");

  nop_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
    accept && op == misc_pkg::OP_NOP |-> !rf_wa_en && !rf_wb_en ##1
      instr_ready && !mem_req && $stable(condition_code_reg) && $stable(irq_level_mask))
    else $error("no-operation changed state");

endmodule

// *** misc_partner.sv ***
`timescale 1ns/10ps
// register file and 256-byte memory facing the execute block
module misc_partner (
  // clock
  input  wire logic        clk_sys,
  // register file
  input  wire logic [3:0]  rf_rd_a_addr,
  output logic      [31:0] rf_rd_a_data,
  input  wire logic [3:0]  rf_rd_b_addr,
  output logic      [31:0] rf_rd_b_data,
  input  wire logic        rf_wa_en,
  input  wire logic [3:0]  rf_wa_addr,
  input  wire logic [31:0] rf_wa_data,
  input  wire logic        rf_wb_en,
  input  wire logic [3:0]  rf_wb_addr,
  input  wire logic [31:0] rf_wb_data,
  // memory
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_byte,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic      [31:0] mem_rdata
);
  logic [31:0] rf [16];
  logic [7:0]  mem [256];
  logic [31:0] junk_r = 32'h5A5A_A5A5;
  logic [7:0]  a;
  initial begin
    for (int k = 0; k < 16; k++) rf[k] = 32'h9E37_79B9 * (k + 1);
    for (int k = 0; k < 256; k++) mem[k] = 8'(k) ^ 8'h5A;
  end
  assign a = mem_addr[7:0];
  assign rf_rd_a_data = rf[rf_rd_a_addr];
  assign rf_rd_b_data = rf[rf_rd_b_addr];
  // outside a window the data lines churn, so a stale read cannot pass
  assign mem_rdata = !mem_req ? junk_r : mem_byte ? {junk_r[31:8], mem[a]} :
                     {mem[a], mem[a + 8'h01], mem[a + 8'h02], mem[a + 8'h03]};
  always @(posedge clk_sys) begin
    junk_r <= ~junk_r ^ 32'h0000_0001;
    if (rf_wa_en) rf[rf_wa_addr] <= rf_wa_data;
    if (rf_wb_en) rf[rf_wb_addr] <= rf_wb_data;
    if (mem_req && mem_we && mem_byte) mem[a] <= mem_wdata[7:0];
    if (mem_req && mem_we && !mem_byte) begin
      {mem[a], mem[a + 8'h01], mem[a + 8'h02], mem[a + 8'h03]} <= mem_wdata;
    end
  end
endmodule

// *** testbench.sv ***
`timescale 1ns/10ps
module testbench;
  localparam int A = 3;
  localparam int B = 2;
  localparam int C = 2;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        instr_valid = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic        instr_ready, op_unknown, rf_wa_en, rf_wb_en, mem_req, mem_we, mem_byte;
  logic [3:0]  rf_rd_a_addr, rf_rd_b_addr, rf_wa_addr, rf_wb_addr;
  logic [31:0] rf_rd_a_data, rf_rd_b_data, rf_wa_data, rf_wb_data, mem_addr, mem_wdata;
  logic [31:0] mem_rdata, t;
  logic [31:0] sh [16];
  logic [31:0] seed = 32'h1196;
  logic [7:0]  condition_code_reg, irq_level_mask, ccr_x, ilm_x, f;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          n, i, j;
  misc_instruction_execute #(.CYC_A(A), .CYC_B(B), .CYC_C(C)) i_misc_instruction_execute (
    .clk_sys, .rst, .instr_valid, .instr, .instr_ready, .op_unknown, .rf_rd_a_addr,
    .rf_rd_a_data, .rf_rd_b_addr, .rf_rd_b_data, .rf_wa_en, .rf_wa_addr, .rf_wa_data,
    .rf_wb_en, .rf_wb_addr, .rf_wb_data, .mem_req, .mem_we, .mem_byte, .mem_addr,
    .mem_wdata, .mem_rdata, .condition_code_reg, .irq_level_mask);
  misc_partner i_misc_partner (
    .clk_sys, .rf_rd_a_addr, .rf_rd_a_data, .rf_rd_b_addr, .rf_rd_b_data, .rf_wa_en,
    .rf_wa_addr, .rf_wa_data, .rf_wb_en, .rf_wb_addr, .rf_wb_data, .mem_req, .mem_we,
    .mem_byte, .mem_addr, .mem_wdata, .mem_rdata);
  always #20 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] ext(input logic [31:0] v, input int m);
    case (m)
      0: ext = {{24{v[7]}}, v[7:0]};
      1: ext = {24'h0, v[7:0]};
      2: ext = {{16{v[15]}}, v[15:0]};
      default: ext = {16'h0, v[15:0]};
    endcase
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one instruction; cycles counted until ready returns, then registers, condition codes and level mask compared
  task automatic exec(input logic [15:0] w, input int nc, input logic unk);
    int k;
    k = 1;
    @(negedge clk_sys);
    instr_valid = 1'b1;
    instr = w;
    #1 check("unknown", {31'h0, op_unknown}, {31'h0, unk});
    @(negedge clk_sys);
    instr_valid = 1'b0;
    while (instr_ready !== 1'b1 && k < 600) begin
      k++;
      @(negedge clk_sys);
    end
    check("cycles", 32'(k), 32'(nc));
    for (int r = 0; r < 16; r++) check("reg", i_misc_partner.rf[r], sh[r]);
    check("ccr", {24'h0, condition_code_reg}, {24'h0, ccr_x});
    check("ilm", {24'h0, irq_level_mask}, {24'h0, ilm_x});
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int r = 0; r < 16; r++) sh[r] = 32'h9E37_79B9 * (r + 1);
    ccr_x = 8'h00;
    ilm_x = 8'h00;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    i = rnd() % 7;
    j = 7 + rnd() % 7;
    f = sh[i][7:0];
    sh[i] = {24'h0, sh[j][7:0] ^ 8'h5A};
    exec({8'h8A, j[3:0], i[3:0]}, 2 * A, 1'b0);
    sh[i] = {24'h0, f};
    exec({8'h8A, j[3:0], i[3:0]}, 2 * A, 1'b0);
    repeat (4) begin
      f = 8'(rnd());
      ccr_x = ccr_x | f;
      exec({8'h93, f}, C, 1'b0);
      f = 8'(rnd());
      ccr_x = ccr_x & f;
      exec({8'h83, f}, C, 1'b0);
      f = 8'(rnd());
      ilm_x = f;
      exec({8'h87, f}, 1, 1'b0);
    end
    for (int k = 0; k < 3; k++) begin
      f = (k == 0) ? 8'h80 : (k == 1) ? 8'h7F : 8'(rnd());
      sh[15] = sh[15] + {{22{f[7]}}, f, 2'b00};
      exec({8'hA3, f}, 1, 1'b0);
    end
    for (int m = 0; m < 4; m++) begin
      i = rnd() % 14;
      sh[i] = ext(sh[i], m);
      exec({8'h97, 4'h8 + 4'(m), i[3:0]}, 1, 1'b0);
    end
    exec(16'h8E00, 1, 1'b0);
    exec(16'h8C00, 1, 1'b0);
    for (int d = 0; d < 2; d++) begin
      f = (8'(rnd()) & ((d == 0) ? 8'h7F : 8'h3F)) | 8'h01;
      n = $countones(f);
      sh[15] = sh[15] - 32'(4 * n);
      exec({(d == 0) ? 8'h8E : 8'h8F, f}, A * n + 1, 1'b0);
      for (int b = 0; b < 8; b++) if (f[b]) sh[(d == 0) ? 8 + b : b] = sh[(d == 0) ? b : 8 + b];
      sh[15] = sh[15] + 32'(4 * n);
      exec({(d == 0) ? 8'h8D : 8'h8C, f}, A * (n - 1) + B + 1, 1'b0);
    end
    f = 8'(rnd());
    t = sh[14];
    sh[14] = sh[15] - 32'h4;
    sh[15] = sh[15] - {22'h0, f, 2'b00};
    exec({8'h0F, f}, 1 + A, 1'b0);
    sh[15] = sh[14] + 32'h4;
    sh[14] = t;
    exec(16'h9F90, B, 1'b0);
    exec(16'h9FA0, 1, 1'b0);
    exec(16'h0000, 1, 1'b1);
    exec(16'h9F00, 1, 1'b1);
    report_and_stop();
  end
endmodule
